// ### verilog/three_phase_modulator.sv
// Three-phase center-aligned gate modulator with AXI4-Lite registers
`timescale 1ns/10ps
module three_phase_modulator (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fault_pin,
    output three_phase_pkg::gate_out_type gates,
    output logic adc_trigger
);
    import three_phase_pkg::*;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_value,
                                          input logic [31:0] new_value,
                                          input logic [3:0] strobe);
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strobe[i]) begin
                result[8*i +: 8] = new_value[8*i +: 8];
            end
        end
        return result;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg, rdata_next;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg, rresp_next;
    logic do_write, write_hit;
    logic [31:0] write_value, old_word;
    logic [1:0] ctrl_reg;
    logic [15:0] cmd_reg [3];
    logic [15:0] scale_reg, dead_ns_reg, freq_reg, freq_clamped;
    logic [16:0] sample_reg;
    logic fault_meta_reg, fault_sync_reg, fault_latch_reg, enable_prev_reg;
    logic fault_active, enable_rise, run, amp_enable_reg;
    div_state_type div_state_reg;
    logic [4:0] div_count_reg;
    logic [15:0] div_rem_reg, div_divisor_reg, half_period_reg;
    logic [25:0] div_dvd_reg;
    logic [16:0] div_rem_shift;
    logic div_fits;
    logic [16:0] pos_reg, period_last, tri_pos, trig_point;
    logic [33:0] trig_product;
    logic period_end;
    logic [15:0] cmd_q [3];
    logic [15:0] scale_q, dead_ns_q, half_q, dead_cycles;
    logic [16:0] sample_q;
    logic [2:0] raw_high;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data taken in either order, response after both
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= write_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Decode of writable offsets; status and unmapped get SLVERR
    always_comb begin
        case ({awaddr_reg[7:2], 2'b00})
            ADDR_CTRL, ADDR_CMD_A, ADDR_CMD_B, ADDR_CMD_C, ADDR_HALF_SCALE,
            ADDR_DEAD_NS, ADDR_SAMPLE, ADDR_FREQ: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Addressed word merged with the written lanes; frequency clipped to its band
    always_comb begin
        case ({awaddr_reg[7:2], 2'b00})
            ADDR_CTRL: old_word = {30'h0000_0000, ctrl_reg};
            ADDR_CMD_A: old_word = {16'h0000, cmd_reg[0]};
            ADDR_CMD_B: old_word = {16'h0000, cmd_reg[1]};
            ADDR_CMD_C: old_word = {16'h0000, cmd_reg[2]};
            ADDR_HALF_SCALE: old_word = {16'h0000, scale_reg};
            ADDR_DEAD_NS: old_word = {16'h0000, dead_ns_reg};
            ADDR_SAMPLE: old_word = {15'h0000, sample_reg};
            default: old_word = {16'h0000, freq_reg};
        endcase
        write_value = merge(old_word, wdata_reg, wstrb_reg);
        if (write_value[15:0] < FREQ_MIN) begin
            freq_clamped = FREQ_MIN;
        end else if (write_value[31:16] != 16'h0000 || write_value[15:0] > FREQ_MAX) begin
            freq_clamped = FREQ_MAX;
        end else begin
            freq_clamped = write_value[15:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= 2'b00;
            for (int i = 0; i < 3; i++) begin
                cmd_reg[i] <= 16'h0000;
            end
            scale_reg <= SCALE_RESET;
            dead_ns_reg <= DEAD_NS_RESET;
            sample_reg <= SAMPLE_RESET;
            freq_reg <= FREQ_RESET;
        end else if (do_write) begin
            case ({awaddr_reg[7:2], 2'b00})
                ADDR_CTRL: ctrl_reg <= write_value[1:0];
                ADDR_CMD_A: cmd_reg[0] <= write_value[15:0];
                ADDR_CMD_B: cmd_reg[1] <= write_value[15:0];
                ADDR_CMD_C: cmd_reg[2] <= write_value[15:0];
                ADDR_HALF_SCALE: scale_reg <= write_value[15:0];
                ADDR_DEAD_NS: dead_ns_reg <= write_value[15:0];
                ADDR_SAMPLE: begin
                    sample_reg <= (write_value > 32'(SAMPLE_MAX)) ? SAMPLE_MAX
                                                                  : write_value[16:0];
                end
                ADDR_FREQ: freq_reg <= freq_clamped;
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;
        rresp_next = RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            ADDR_CTRL: rdata_next[1:0] = ctrl_reg;
            ADDR_STATUS: begin
                rdata_next[STATUS_FAULT_BIT] = fault_latch_reg;
                rdata_next[STATUS_RUN_BIT] = run;
                rdata_next[STATUS_DIV_BUSY_BIT] = (div_state_reg == DIV_BUSY);
                rdata_next[STATUS_FAULT_PIN_BIT] = fault_active;
            end
            ADDR_CMD_A: rdata_next[15:0] = cmd_reg[0];
            ADDR_CMD_B: rdata_next[15:0] = cmd_reg[1];
            ADDR_CMD_C: rdata_next[15:0] = cmd_reg[2];
            ADDR_HALF_SCALE: rdata_next[15:0] = scale_reg;
            ADDR_DEAD_NS: rdata_next[15:0] = dead_ns_reg;
            ADDR_SAMPLE: rdata_next[16:0] = sample_reg;
            ADDR_FREQ: rdata_next[15:0] = freq_reg;
            default: rresp_next = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Fault input and enable
    // ------------------------------------------------------------
    // Pin is asynchronous: two flops before any decision
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_meta_reg <= 1'b1;
            fault_sync_reg <= 1'b1;
        end else begin
            fault_meta_reg <= fault_pin;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    assign fault_active = ctrl_reg[CTRL_FAULT_INVERT_BIT] ? fault_sync_reg
                                                          : !fault_sync_reg;
    assign enable_rise = ctrl_reg[CTRL_ENABLE_BIT] && !enable_prev_reg;
    assign run = ctrl_reg[CTRL_ENABLE_BIT] && !fault_latch_reg;

    // Set wins over the enable-edge clear, so a fault is never lost
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_prev_reg <= 1'b0;
            fault_latch_reg <= 1'b0;
        end else begin
            enable_prev_reg <= ctrl_reg[CTRL_ENABLE_BIT];
            if (fault_active) begin
                fault_latch_reg <= 1'b1;
            end else if (enable_rise) begin
                fault_latch_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Half-period divider
    // ------------------------------------------------------------
    // Serial restoring divide, 26 cycles; avoids a wide combinational divider
    assign div_rem_shift = {div_rem_reg, div_dvd_reg[25]};
    assign div_fits = div_rem_shift >= {1'b0, div_divisor_reg};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_state_reg <= DIV_IDLE;
            div_count_reg <= 5'h00;
            div_rem_reg <= 16'h0000;
            div_dvd_reg <= 26'h000_0000;
            div_divisor_reg <= FREQ_RESET;
            half_period_reg <= HALF_PERIOD_RESET;
        end else if (do_write && {awaddr_reg[7:2], 2'b00} == ADDR_FREQ) begin
            div_state_reg <= DIV_BUSY;
            div_count_reg <= 5'h00;
            div_rem_reg <= 16'h0000;
            div_dvd_reg <= HALF_CLOCK;
            div_divisor_reg <= freq_clamped;
        end else begin
            case (div_state_reg)
                DIV_IDLE: div_count_reg <= 5'h00;
                DIV_BUSY: begin
                    div_rem_reg <= div_fits ? 16'(div_rem_shift - {1'b0, div_divisor_reg})
                                            : div_rem_shift[15:0];
                    div_dvd_reg <= {div_dvd_reg[24:0], div_fits};
                    div_count_reg <= div_count_reg + 5'h01;
                    if (div_count_reg == DIV_STEPS - 5'h01) begin
                        half_period_reg <= {div_dvd_reg[14:0], div_fits};
                        div_state_reg <= DIV_IDLE;
                    end
                end
                default: div_state_reg <= DIV_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Period counter and period-start latching
    // ------------------------------------------------------------
    // Counter shared by all three phases, so one frequency for all
    assign period_last = {half_q, 1'b0} - 17'h0_0001;
    assign period_end = (pos_reg >= period_last);
    assign tri_pos = (pos_reg < {1'b0, half_q}) ? pos_reg : period_last - pos_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_reg <= 17'h0_0000;
            half_q <= HALF_PERIOD_RESET;
            scale_q <= SCALE_RESET;
            dead_ns_q <= DEAD_NS_RESET;
            sample_q <= SAMPLE_RESET;
            for (int i = 0; i < 3; i++) begin
                cmd_q[i] <= 16'h0000;
            end
        end else if (period_end) begin
            pos_reg <= 17'h0_0000;
            half_q <= half_period_reg;
            scale_q <= scale_reg;
            dead_ns_q <= dead_ns_reg;
            sample_q <= sample_reg;
            for (int i = 0; i < 3; i++) begin
                cmd_q[i] <= cmd_reg[i];
            end
        end else begin
            pos_reg <= pos_reg + 17'h0_0001;
        end
    end

    // Dead time rounded up to whole clocks
    assign dead_cycles = 16'((32'(dead_ns_q) + CLOCK_PERIOD_NS - 32'h0000_0001)
                             / CLOCK_PERIOD_NS);

    // ------------------------------------------------------------
    // ADC trigger
    // ------------------------------------------------------------
    // Fraction of the period in units of 1/65536, end clipped to last clock
    assign trig_product = 34'(sample_q) * 34'({half_q, 1'b0});
    assign trig_point = (trig_product[33:16] > 18'(period_last)) ? period_last
                                                                 : trig_product[32:16];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= (pos_reg == trig_point);
        end
    end

    // ------------------------------------------------------------
    // Per-phase comparators and gate legs
    // ------------------------------------------------------------
    // High when (2t+1)*scale > half*(scale-cmd): zero gives 50%, -scale 0%
    for (genvar p = 0; p < 3; p++) begin : g_phase
        logic signed [17:0] cmd_clip;
        logic [16:0] cmd_span;
        logic [33:0] lhs, thr;

        always_comb begin
            if ($signed({{2{cmd_q[p][15]}}, cmd_q[p]}) > $signed({2'b00, scale_q})) begin
                cmd_clip = $signed({2'b00, scale_q});
            end else if ($signed({{2{cmd_q[p][15]}}, cmd_q[p]}) < -$signed({2'b00, scale_q})) begin
                cmd_clip = -$signed({2'b00, scale_q});
            end else begin
                cmd_clip = $signed({{2{cmd_q[p][15]}}, cmd_q[p]});
            end
        end

        assign cmd_span = 17'($signed({2'b00, scale_q}) - cmd_clip);
        assign lhs = 34'({tri_pos, 1'b1}) * 34'(scale_q);
        assign thr = 34'(half_q) * 34'(cmd_span);
        assign raw_high[p] = lhs > thr;

        phase_gate u_leg (
            .clk(clk),
            .reset(reset),
            .run(run),
            .raw_high(raw_high[p]),
            .dead_cycles(dead_cycles),
            .high_out(gates.high[p]),
            .low_out(gates.complementary_low_output[p])
        );
    end

    // Amplifier enable follows the run state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            amp_enable_reg <= 1'b0;
        end else begin
            amp_enable_reg <= run;
        end
    end

    assign gates.amp_enable = amp_enable_reg;

endmodule // three_phase_modulator

// ### shared/three_phase_pkg.sv
// Constants, types and register map for the three-phase gate modulator
package three_phase_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam logic [31:0] CLOCK_HZ = 32'h05f5_e100;
    localparam logic [31:0] CLOCK_PERIOD_NS = 32'h0000_000a;
    localparam logic [25:0] HALF_CLOCK = 26'(CLOCK_HZ / 32'h0000_0002);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CMD_A = 8'h08;
    localparam logic [7:0] ADDR_CMD_B = 8'h0c;
    localparam logic [7:0] ADDR_CMD_C = 8'h10;
    localparam logic [7:0] ADDR_HALF_SCALE = 8'h14;
    localparam logic [7:0] ADDR_DEAD_NS = 8'h18;
    localparam logic [7:0] ADDR_SAMPLE = 8'h1c;
    localparam logic [7:0] ADDR_FREQ = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FAULT_INVERT_BIT = 1;
    localparam int STATUS_FAULT_BIT = 0;
    localparam int STATUS_RUN_BIT = 1;
    localparam int STATUS_DIV_BUSY_BIT = 2;
    localparam int STATUS_FAULT_PIN_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] DEAD_NS_RESET = 16'h1388;
    localparam logic [15:0] SCALE_RESET = 16'h0100;
    localparam logic [16:0] SAMPLE_RESET = 17'h0_8000;
    localparam logic [16:0] SAMPLE_MAX = 17'h1_0000;
    localparam logic [15:0] FREQ_RESET = 16'h4e20;
    localparam logic [15:0] FREQ_MIN = 16'h03e8;
    localparam logic [15:0] FREQ_MAX = 16'hbb80;
    localparam logic [15:0] HALF_PERIOD_RESET = 16'(HALF_CLOCK / 26'(FREQ_RESET));
    localparam logic [4:0] DIV_STEPS = 5'h1a;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_BUSY = 2'b10
    } div_state_type;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] complementary_low_output;
        logic amp_enable;
    } gate_out_type;

endpackage

// ### verilog/phase_gate.sv
// One phase leg: dead-time insertion between complementary gates
`timescale 1ns/10ps
module phase_gate (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic raw_high,
    input wire logic [15:0] dead_cycles,
    output logic high_out,
    output logic low_out
);
    import three_phase_pkg::*;

    logic last_raw_reg;
    logic [15:0] dead_count_reg;
    logic settled;

    // Gap is over when the wanted side has waited out twice its dead time
    assign settled = (raw_high == last_raw_reg) ? (dead_count_reg == 16'h0000)
                                                : (dead_cycles == 16'h0000);

    // ------------------------------------------------------------
    // Dead-time counter
    // ------------------------------------------------------------
    // Gap of twice the dead time, so each pulse loses it twice at its leading edge and not at all at its trailing edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_raw_reg <= 1'b0;
            dead_count_reg <= 16'h0000;
        end else if (raw_high != last_raw_reg) begin
            last_raw_reg <= raw_high;
            dead_count_reg <= (dead_cycles == 16'h0000) ? 16'h0000
                              : {dead_cycles[14:0], 1'b0} - 16'h0001;
        end else if (dead_count_reg != 16'h0000) begin
            dead_count_reg <= dead_count_reg - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------
    // Both off while stopped or inside the gap, never both on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            high_out <= 1'b0;
            low_out <= 1'b0;
        end else begin
            high_out <= run && raw_high && settled;
            low_out <= run && !raw_high && settled;
        end
    end

endmodule // phase_gate

// ### bench/three_phase_sva.sv
// Concurrent checks on the modulator's bus and gate ports
`timescale 1ns/10ps
module three_phase_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire three_phase_pkg::gate_out_type gates,
    input wire logic adc_trigger
);
    import three_phase_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Dead gap; the bench never sets it below eight clocks
    sequence low_a_idle; !gates.complementary_low_output[0] [*8]; endsequence
    sequence high_a_idle; !gates.high[0] [*8]; endsequence
    chk_no_overlap: assert property (
        (gates.high & gates.complementary_low_output) == 3'h0) else $error("both gates on");
    chk_dead_fall: assert property (
        $fell(gates.high[0]) |-> low_a_idle) else $error("low gate on inside dead time");
    chk_dead_rise: assert property (
        $fell(gates.complementary_low_output[0]) |-> high_a_idle) else $error("early high gate");
    chk_off_quiet: assert property (
        !gates.amp_enable [*2] |-> gates.high == 3'h0 && gates.complementary_low_output == 3'h0)
        else $error("gates active while amplifier off");
    chk_adc_pulse: assert property (
        adc_trigger |=> !adc_trigger) else $error("trigger longer than one clock");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule // three_phase_sva
bind three_phase_modulator three_phase_sva three_phase_sva_i (.clk, .reset, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .gates, .adc_trigger);

// ### bench/bridge_model.sv
// Bridge driver stand-in: over-current sense on a pulled-up open-drain fault line
`timescale 1ns/10ps
module bridge_model (
    input wire logic trip,
    input wire three_phase_pkg::gate_out_type gates,
    output logic fault_pin
);
    import three_phase_pkg::*;
    // A shorted leg trips too, so shoot-through is never forgiven
    assign fault_pin = !(trip || |(gates.high & gates.complementary_low_output));
endmodule // bridge_model

// ### bench/tb_three_phase_modulator.sv
// Self-checking bench for the three-phase modulator
`timescale 1ns/10ps
module tb_three_phase_modulator;
    import three_phase_pkg::*;
    localparam int HALF = 2500;
    logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic trip = 0, fault_pin, adc_trigger, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp;
    gate_out_type gates;
    int miscompares = 0, check_count = 0, hc[3], lc[3], ac;
    logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [31:0] rv[8] = '{0, 0, 0, 0, 32'h0000_0100, 32'h0000_1388, 32'h0000_8000, 32'h0000_4e20};
    three_phase_modulator three_phase_modulator_i (.clk, .reset, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fault_pin,
        .gates, .adc_trigger);
    bridge_model bridge_model_i (.trip, .gates, .fault_pin);
    // Free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic timeout;
        miscompares++;
        results();
    endtask
    // Both halves offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (++n > 100) timeout();
        end while (!bvalid);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (++n > 100) timeout();
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        check({30'h0, rresp}, {30'h0, er});
    endtask
    // Two triggers first so the window holds settings from one period only
    task automatic meas;
        int n = 0;
        repeat (2) begin
            do begin
                @(posedge clk);
                if (++n > 12000) timeout();
            end while (!adc_trigger);
        end
        hc = '{0, 0, 0};
        lc = '{0, 0, 0};
        ac = 0;
        repeat (2 * HALF) begin
            for (int i = 0; i < 3; i++) begin
                hc[i] += gates.high[i];
                lc[i] += gates.complementary_low_output[i];
            end
            ac += adc_trigger;
            @(posedge clk);
        end
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check({25'h0, gates}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], RESP_OKAY, d);
            check(d, rv[i]);
        end
        rd(8'h24, RESP_SLVERR, d);
        wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        meas();
        for (int i = 0; i < 3; i++) begin
            check(hc[i], HALF - 1000);
            check(lc[i], HALF - 1000);
        end
        check(ac, 1);
        wr(ADDR_DEAD_NS, 32'h0000_0064, RESP_OKAY);
        wr(ADDR_CMD_A, 32'h0000_ff00, RESP_OKAY);
        wr(ADDR_CMD_C, 32'h0000_0100, RESP_OKAY);
        meas();
        check(hc[0], 0);
        check(lc[0], 2 * HALF);
        check(hc[1], HALF - 20);
        check(lc[1], HALF - 20);
        check(hc[2] + lc[2], 2 * HALF);
        trip <= 1'b1;
        repeat (6) @(posedge clk);
        check({25'h0, gates}, 32'h0);
        rd(ADDR_STATUS, RESP_OKAY, d);
        check({31'h0, d[0]}, 32'h1);
        trip <= 1'b0;
        repeat (6) @(posedge clk);
        rd(ADDR_STATUS, RESP_OKAY, d);
        check({31'h0, d[0]}, 32'h1);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (4) @(posedge clk);
        rd(ADDR_STATUS, RESP_OKAY, d);
        check({31'h0, d[0]}, 32'h0);
        check({31'h0, gates.amp_enable}, 32'h1);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        repeat (6) @(posedge clk);
        check({31'h0, gates.amp_enable}, 32'h0);
        results();
    end
endmodule // tb_three_phase_modulator
